// ==== rtl/osc_seq_pkg.sv ====
`default_nettype none
package osc_seq_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0]  CFG_OFFSET     = 8'h00;
    localparam logic [7:0]  STATUS_OFFSET  = 8'h04;
    localparam int          CFG_M_LSB      = 0;
    localparam int          CFG_N_LSB      = 8;
    localparam int          CFG_REF_EN_BIT = 16;
    localparam int          CFG_EXT_BIT    = 17;
    localparam logic [31:0] CFG_RESET      = 32'h0001_0404;
    localparam logic [1:0]  RESP_OKAY      = 2'h0;
    localparam logic [1:0]  RESP_SLVERR    = 2'h2;

    // ------------------------------------------------------------
    // Sequencing
    // ------------------------------------------------------------
    localparam logic [7:0]  RATIO_MAX        = 8'hff;
    localparam int unsigned STAB_MCLK_CYCLES = 256;

    typedef enum logic [2:0] {
        SEQ_RESET  = 3'h0,
        SEQ_WAIT   = 3'h1,
        SEQ_STAB   = 3'h3,
        SEQ_LOAD   = 3'h2,
        SEQ_REF_ON = 3'h6,
        SEQ_RUN    = 3'h7,
        SEQ_OFF    = 3'h4
    } seq_state_e;

endpackage
`default_nettype wire

// ==== rtl/gated_divider.sv ====
`timescale 1ns/1ps
`default_nettype none
module gated_divider (
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic       tick,
    input  wire logic [7:0] ratio,
    input  wire logic       run,
    input  wire logic       gate,
    output logic            div_out_q
);
    logic [7:0] cnt_q;
    logic [7:0] cnt_d;
    logic       div_out_d;
    logic [7:0] last;
    logic       hold;

    always_comb
    begin
        last      = (ratio == 8'h00) ? 8'h00 : ratio - 8'h01;
        hold      = !run || (!gate && !div_out_q);
        cnt_d     = cnt_q;
        div_out_d = div_out_q;
        if (hold)
        begin
            cnt_d     = 8'h00;
            div_out_d = 1'b0;
        end
        else if (tick)
        begin
            if (cnt_q >= last)
            begin
                cnt_d     = 8'h00;
                div_out_d = !div_out_q;
            end
            else
            begin
                cnt_d = cnt_q + 8'h01;
            end
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            cnt_q     <= 8'h00;
            div_out_q <= 1'b0;
        end
        else
        begin
            cnt_q     <= cnt_d;
            div_out_q <= div_out_d;
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_gate_holds_low;
        (!gate && !div_out_q) |=> !div_out_q && cnt_q == 8'h00;
    endproperty
    a_gate_holds_low: assert property (p_gate_holds_low)
        else $error("main output moved while gate low");

    property p_high_finishes;
        (run && !gate && div_out_q && !tick) |=> div_out_q;
    endproperty
    a_high_finishes: assert property (p_high_finishes)
        else $error("high pulse truncated by gate");
endmodule // gated_divider
`default_nettype wire

// ==== rtl/oscillator_power_on_sequencer.sv ====
// Register access over AXI4-Lite and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module oscillator_power_on_sequencer #(
    parameter int unsigned STAB_CYCLES = osc_seq_pkg::STAB_MCLK_CYCLES
) (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    input  wire logic [7:0]  araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    input  wire logic        external_clock_in,
    input  wire logic        output_gate_in,
    input  wire logic        sleep_request_low,
    output logic             reference_clock_out,
    output logic             gated_clock_out
);
    import osc_seq_pkg::*;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [2:0] pin_raw;
    logic [2:0] sync1_q;
    logic [2:0] sync2_q;
    logic       ext_s;
    logic       gate_s;
    logic       awake_s;

    assign pin_raw = {external_clock_in, output_gate_in, sleep_request_low};

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++)
        begin : g_sync
            always_ff @(posedge aclk)
            begin
                if (!aresetn)
                begin
                    sync1_q[gi] <= 1'b0;
                    sync2_q[gi] <= 1'b0;
                end
                else
                begin
                    sync1_q[gi] <= pin_raw[gi];
                    sync2_q[gi] <= sync1_q[gi];
                end
            end
        end
    endgenerate

    assign {ext_s, gate_s, awake_s} = sync2_q;

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    seq_state_e  state_q, state_d;
    logic [31:0] cfg_q, cfg_d;
    logic [7:0]  m_q, m_d, n_q, n_d, pre_q, pre_d, m_eff;
    logic [15:0] stab_q, stab_d;
    logic        ext_prev_q, gate_smp_q, gate_smp_d, ref_q, ref_d;
    logic        src_tick, mclk_tick, stab_done, osc_run, ext_mode;

    assign ext_mode  = cfg_q[CFG_EXT_BIT];
    assign osc_run   = state_q inside {SEQ_STAB, SEQ_LOAD, SEQ_REF_ON, SEQ_RUN};
    assign m_eff     = (state_q inside {SEQ_REF_ON, SEQ_RUN}) ? m_q : RATIO_MAX;
    assign src_tick  = ext_mode ? (ext_s && !ext_prev_q) : 1'b1;
    // Ratio 0 behaves as 1; without the zero test it would wrap to 256
    assign mclk_tick = osc_run && src_tick && (m_eff == 8'h00 || pre_q >= m_eff - 8'h01);
    assign stab_done = mclk_tick && (stab_q == 16'(STAB_CYCLES - 1));

    always_comb
    begin
        state_d    = state_q;
        m_d        = m_q;
        n_d        = n_q;
        stab_d     = stab_q;
        pre_d      = pre_q;
        gate_smp_d = gate_smp_q;
        ref_d      = ref_q;
        if (osc_run && src_tick)
        begin
            pre_d = mclk_tick ? 8'h00 : pre_q + 8'h01;
        end
        if (mclk_tick)
        begin
            gate_smp_d = gate_s;
        end
        if (state_q inside {SEQ_REF_ON, SEQ_RUN} && cfg_q[CFG_REF_EN_BIT])
        begin
            ref_d = mclk_tick ? !ref_q : ref_q;
        end
        else
        begin
            ref_d = 1'b0;
        end
        case (state_q)
            SEQ_RESET:
            begin
                stab_d     = 16'h0000;
                pre_d      = 8'h00;
                m_d        = RATIO_MAX;
                n_d        = RATIO_MAX;
                gate_smp_d = 1'b0;
                state_d    = SEQ_WAIT;
            end
            SEQ_WAIT:
            begin
                if (gate_s)
                begin
                    state_d = SEQ_STAB;
                end
            end
            SEQ_STAB:
            begin
                if (stab_done)
                begin
                    state_d = SEQ_LOAD;
                end
                else if (mclk_tick)
                begin
                    stab_d = stab_q + 16'h0001;
                end
            end
            SEQ_LOAD:
            begin
                m_d     = cfg_q[CFG_M_LSB +: 8];
                n_d     = cfg_q[CFG_N_LSB +: 8];
                state_d = SEQ_REF_ON;
            end
            SEQ_REF_ON: state_d = SEQ_RUN;
            SEQ_RUN:    state_d = SEQ_RUN;
            SEQ_OFF:
            begin
                if (awake_s)
                begin
                    state_d = SEQ_RESET;
                end
            end
            default:    state_d = SEQ_RESET;
        endcase
        // Sleep overrides the next state and the reference output; restore replays the full power-up path
        if (!awake_s)
        begin
            state_d = SEQ_OFF;
            ref_d   = 1'b0;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state_q    <= SEQ_RESET;
            m_q        <= RATIO_MAX;
            n_q        <= RATIO_MAX;
            stab_q     <= 16'h0000;
            pre_q      <= 8'h00;
            ext_prev_q <= 1'b0;
            gate_smp_q <= 1'b0;
            ref_q      <= 1'b0;
        end
        else
        begin
            state_q    <= state_d;
            m_q        <= m_d;
            n_q        <= n_d;
            stab_q     <= stab_d;
            pre_q      <= pre_d;
            ext_prev_q <= ext_s;
            gate_smp_q <= gate_smp_d;
            ref_q      <= ref_d;
        end
    end

    assign reference_clock_out = ref_q;

    gated_divider gated_divider_i (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .tick      (mclk_tick),
        .ratio     (n_q),
        .run       (state_q == SEQ_RUN),
        .gate      (gate_smp_q),
        .div_out_q (gated_clock_out)
    );

    // ------------------------------------------------------------
    // AXI4-Lite slave
    // ------------------------------------------------------------
    logic        aw_full_q, aw_full_d, w_full_q, w_full_d;
    logic [7:0]  aw_addr_q, aw_addr_d;
    logic [31:0] w_data_q, w_data_d, rdata_d;
    logic [3:0]  w_strb_q, w_strb_d;
    logic        awready_d, wready_d, bvalid_d, arready_d, rvalid_d;
    logic [1:0]  bresp_d, rresp_d;
    logic [31:0] status_word;

    assign status_word = {8'h00, n_q, m_q, 1'b0, awake_s, gate_smp_q,
                          gated_clock_out, ref_q, state_q};

    always_comb
    begin
        aw_full_d = aw_full_q;
        aw_addr_d = aw_addr_q;
        w_full_d  = w_full_q;
        w_data_d  = w_data_q;
        w_strb_d  = w_strb_q;
        bvalid_d  = bvalid;
        bresp_d   = bresp;
        rvalid_d  = rvalid;
        rresp_d   = rresp;
        rdata_d   = rdata;
        cfg_d     = cfg_q;
        if (awvalid && awready)
        begin
            aw_full_d = 1'b1;
            aw_addr_d = awaddr;
        end
        if (wvalid && wready)
        begin
            w_full_d = 1'b1;
            w_data_d = wdata;
            w_strb_d = wstrb;
        end
        if (bvalid && bready)
        begin
            bvalid_d = 1'b0;
        end
        if (aw_full_q && w_full_q && !bvalid)
        begin
            aw_full_d = 1'b0;
            w_full_d  = 1'b0;
            bvalid_d  = 1'b1;
            bresp_d   = RESP_OKAY;
            if (aw_addr_q == CFG_OFFSET)
            begin
                for (int b = 0; b < 4; b++)
                begin
                    if (w_strb_q[b])
                    begin
                        cfg_d[8*b +: 8] = w_data_q[8*b +: 8];
                    end
                end
            end
            else if (aw_addr_q != STATUS_OFFSET)
            begin
                bresp_d = RESP_SLVERR;
            end
        end
        if (rvalid && rready)
        begin
            rvalid_d = 1'b0;
        end
        if (arvalid && arready)
        begin
            rvalid_d = 1'b1;
            rresp_d  = RESP_OKAY;
            case (araddr)
                CFG_OFFSET:    rdata_d = cfg_q;
                STATUS_OFFSET: rdata_d = status_word;
                default:
                begin
                    rdata_d = 32'h0000_0000;
                    rresp_d = RESP_SLVERR;
                end
            endcase
        end
        awready_d = !aw_full_d;
        wready_d  = !w_full_d;
        arready_d = !rvalid_d;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_full_q <= 1'b0;
            aw_addr_q <= 8'h00;
            w_full_q  <= 1'b0;
            w_data_q  <= 32'h0000_0000;
            w_strb_q  <= 4'h0;
            awready   <= 1'b0;
            wready    <= 1'b0;
            bvalid    <= 1'b0;
            bresp     <= RESP_OKAY;
            arready   <= 1'b0;
            rvalid    <= 1'b0;
            rresp     <= RESP_OKAY;
            rdata     <= 32'h0000_0000;
            cfg_q     <= CFG_RESET;
        end
        else
        begin
            aw_full_q <= aw_full_d;
            aw_addr_q <= aw_addr_d;
            w_full_q  <= w_full_d;
            w_data_q  <= w_data_d;
            w_strb_q  <= w_strb_d;
            awready   <= awready_d;
            wready    <= wready_d;
            bvalid    <= bvalid_d;
            bresp     <= bresp_d;
            arready   <= arready_d;
            rvalid    <= rvalid_d;
            rresp     <= rresp_d;
            rdata     <= rdata_d;
            cfg_q     <= cfg_d;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_load;
        state_q == SEQ_LOAD && awake_s;
    endsequence
    sequence s_ref_then_run;
        state_q == SEQ_REF_ON ##1 state_q == SEQ_RUN;
    endsequence

    property p_reset_stage;
        (state_q == SEQ_RESET && awake_s) |=> state_q == SEQ_WAIT && stab_q == 16'h0000;
    endproperty
    a_reset_stage: assert property (p_reset_stage)
        else $error("reset stage did not clear the wait counter");

    property p_max_ratio;
        state_q == SEQ_STAB |-> m_eff == RATIO_MAX && n_q == RATIO_MAX;
    endproperty
    a_max_ratio: assert property (p_max_ratio)
        else $error("ratios not at maximum during wait");

    property p_wait_holds;
        (state_q == SEQ_STAB && !stab_done && awake_s) |=> state_q == SEQ_STAB;
    endproperty
    a_wait_holds: assert property (p_wait_holds)
        else $error("wait left before terminal count");

    property p_load_order;
        s_load |=> s_ref_then_run;
    endproperty
    a_load_order: assert property (p_load_order)
        else $error("outputs not enabled in order after load");

    property p_quiet_in_wait;
        state_q inside {SEQ_WAIT, SEQ_STAB} |-> !reference_clock_out && !gated_clock_out;
    endproperty
    a_quiet_in_wait: assert property (p_quiet_in_wait)
        else $error("output active during stabilization");

    property p_gate_postpones;
        (state_q == SEQ_WAIT && !gate_s && awake_s) |=> state_q == SEQ_WAIT;
    endproperty
    a_gate_postpones: assert property (p_gate_postpones)
        else $error("wait started with gate low");

    property p_ext_count;
        (ext_mode && !$rose(ext_s)) |-> !mclk_tick;
    endproperty
    a_ext_count: assert property (p_ext_count)
        else $error("prescaled tick without external edge");

    property p_gate_sample;
        mclk_tick |=> gate_smp_q == $past(gate_s);
    endproperty
    a_gate_sample: assert property (p_gate_sample)
        else $error("gate not sampled on prescaled tick");

endmodule // oscillator_power_on_sequencer
`default_nettype wire

// ==== verif/board_pins_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module board_pins_model (
    input  wire logic gate_level,
    input  wire logic sleep_level,
    input  wire logic ext_run,
    output logic      output_gate_in,
    output logic      sleep_request_low,
    output logic      external_clock_in,
    output int        ext_edges
);
    // ------------------------------------------------------------
    // Board pins
    // ------------------------------------------------------------
    // gate level from board
    assign output_gate_in    = gate_level;
    assign sleep_request_low = sleep_level;

    // Phase unrelated to aclk; the clock stands low while not running
    initial
    begin
        external_clock_in = 1'b0;
        ext_edges         = 0;
        forever
        begin
            #290;
            if (ext_run)
            begin
                external_clock_in = ~external_clock_in;
                if (external_clock_in)
                    ext_edges++;
            end
            else
                external_clock_in = 1'b0;
        end
    end
endmodule // board_pins_model
`default_nettype wire

// ==== verif/oscillator_power_on_sequencer_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module oscillator_power_on_sequencer_tb;
    import osc_seq_pkg::*;
    // ------------------------------------------------------------
    // Bench signals
    // ------------------------------------------------------------
    localparam int unsigned STAB  = 4;
    localparam int          TICKS = STAB * 255;
    logic aclk = 1'b0, aresetn = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0, rdata, d;
    logic [3:0]  wstrb = 4'hf;
    logic [1:0]  bresp, rresp, resp;
    logic awready, wready, bvalid, arready, rvalid, ref_o, main_o, early;
    logic gate_level = 1'b0, sleep_level = 1'b1, ext_run = 1'b0;
    logic gate_pin, sleep_pin, ext_pin;
    int   ext_edges, n_mismatch = 0, cmp_count = 0, cycle = 0, t0, cyc, r, m;

    always #50 aclk = ~aclk;
    always @(posedge aclk) cycle <= cycle + 1;

    oscillator_power_on_sequencer #(.STAB_CYCLES(STAB)) oscillator_power_on_sequencer_i (
        .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
        .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
        .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .external_clock_in(ext_pin), .output_gate_in(gate_pin),
        .sleep_request_low(sleep_pin), .reference_clock_out(ref_o),
        .gated_clock_out(main_o));

    board_pins_model board_pins_model_i (
        .gate_level(gate_level), .sleep_level(sleep_level), .ext_run(ext_run),
        .output_gate_in(gate_pin), .sleep_request_low(sleep_pin),
        .external_clock_in(ext_pin), .ext_edges(ext_edges));

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic timeout(input string what);
        n_mismatch++;
        $display("mismatch %s expected done seen timeout", what);
        end_sim();
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
        logic a_ok, w_ok;
        int   i;
        awaddr  <= a;
        wdata   <= v;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        a_ok = 1'b0;
        w_ok = 1'b0;
        for (i = 0; i < 50 && !(a_ok && w_ok); i++)
        begin
            @(posedge aclk);
            if (!a_ok && awready === 1'b1)
            begin
                a_ok = 1'b1;
                awvalid <= 1'b0;
            end
            if (!w_ok && wready === 1'b1)
            begin
                w_ok = 1'b1;
                wvalid <= 1'b0;
            end
        end
        if (!(a_ok && w_ok))
            timeout("write request");
        for (i = 0; i < 50 && bvalid !== 1'b1; i++)
            @(posedge aclk);
        if (bvalid !== 1'b1)
            timeout("write response");
        rs = bresp;
        bready <= 1'b0;
        @(posedge aclk);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
        int i;
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        for (i = 0; i < 50; i++)
        begin
            @(posedge aclk);
            if (arready === 1'b1)
                break;
        end
        if (i >= 50)
            timeout("read request");
        arvalid <= 1'b0;
        for (i = 0; i < 50 && rvalid !== 1'b1; i++)
            @(posedge aclk);
        if (rvalid !== 1'b1)
            timeout("read response");
        v  = rdata;
        rs = rresp;
        rready <= 1'b0;
        @(posedge aclk);
    endtask

    // Counts edges until the chosen output is high; flags main high before
    task automatic wait_rise(input logic sel, input int bound);
        early = 1'b0;
        for (cyc = 0; cyc < bound; cyc++)
        begin
            @(posedge aclk);
            if ((sel ? main_o : ref_o) === 1'b1)
                break;
            if (main_o !== 1'b0)
                early = 1'b1;
        end
        if (cyc >= bound)
            timeout("clock start");
    endtask

    task automatic watch(input int n);
        r = 0;
        m = 0;
        repeat (n)
        begin
            @(posedge aclk);
            r += (ref_o === 1'b1);
            m += (main_o !== 1'b0);
        end
    endtask

    task automatic state_is(input logic [2:0] s);
        rd(STATUS_OFFSET, d, resp);
        chk("state", {29'h0, s}, {29'h0, d[2:0]});
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic s_reset_and_bus;
        chk("outputs after reset", 32'h0, {30'h0, ref_o, main_o});
        rd(CFG_OFFSET, d, resp);
        chk("config reset", CFG_RESET, d);
        state_is(3'h1);
        rd(8'h08, d, resp);
        chk("unmapped read data", 32'h0, d);
        chk("unmapped read resp", {30'h0, RESP_SLVERR}, {30'h0, resp});
        wr(STATUS_OFFSET, 32'hffff_ffff, resp);
        chk("status write", {30'h0, RESP_OKAY}, {30'h0, resp});
        wr(8'h0c, 32'h1, resp);
        chk("unmapped write", {30'h0, RESP_SLVERR}, {30'h0, resp});
    endtask

    task automatic s_gate_held_low;
        // Ratios M=2 N=3 keep the output above the minimum frequency
        wr(CFG_OFFSET, 32'h0001_0302, resp);
        watch(2000);
        chk("ref while gate low", 32'h0, r);
        chk("main while gate low", 32'h0, m);
        state_is(3'h1);
    endtask

    task automatic s_power_up;
        gate_level <= 1'b1;
        t0 = cycle;
        repeat (20) @(posedge aclk);
        rd(STATUS_OFFSET, d, resp);
        // Awake bit reads 1, sampled gate still 0 before the first tick
        chk("stab state and ratios", {8'h00, 8'hff, 8'hff, 8'h43}, {8'h00, d[23:0]});
        wait_rise(1'b0, 1300);
        chk("stab wait length", 32'h1,
            32'((cycle - t0 >= TICKS) && (cycle - t0 <= TICKS + 40)));
        chk("main before ref", 32'h0, {31'h0, early});
        wait_rise(1'b1, 100);
        rd(STATUS_OFFSET, d, resp);
        // Output bits toggle, so only awake, sampled gate, state and ratios count
        chk("run state and ratios", {10'h0, 8'h03, 8'h02, 3'h3, 3'h7},
            {10'h0, d[23:8], d[7:5], d[2:0]});
    endtask

    task automatic s_gate_stop;
        gate_level <= 1'b0;
        repeat (40) @(posedge aclk);
        watch(200);
        chk("main held low", 32'h0, m);
        chk("ref keeps running", 32'h1, 32'(r > 0));
        gate_level <= 1'b1;
        wait_rise(1'b1, 40);
    endtask

    task automatic s_restore_gate_drop;
        sleep_level <= 1'b0;
        repeat (10) @(posedge aclk);
        state_is(3'h4);
        chk("outputs asleep", 32'h0, {30'h0, ref_o, main_o});
        sleep_level <= 1'b1;
        repeat (300) @(posedge aclk);
        state_is(3'h3);
        gate_level <= 1'b0;
        wait_rise(1'b0, 1300);
        watch(200);
        chk("main after dropped gate", 32'h0, m);
        gate_level <= 1'b1;
    endtask

    task automatic s_external;
        wr(CFG_OFFSET, 32'h0003_0302, resp);
        sleep_level <= 1'b0;
        ext_run     <= 1'b1;
        repeat (10) @(posedge aclk);
        sleep_level <= 1'b1;
        t0 = ext_edges;
        wait_rise(1'b0, 9000);
        chk("external stab edges", 32'h1,
            32'((ext_edges - t0 >= TICKS) && (ext_edges - t0 <= TICKS + 10)));
        chk("main before ref ext", 32'h0, {31'h0, early});
    endtask

    initial
    begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        s_reset_and_bus();
        s_gate_held_low();
        s_power_up();
        s_gate_stop();
        s_restore_gate_drop();
        s_external();
        end_sim();
    end
endmodule // oscillator_power_on_sequencer_tb
`default_nettype wire
